// File: design/srrs_map.svh
// constants for the transceiver reconfiguration reset and status block
`ifndef SRRS_MAP_SVH
`define SRRS_MAP_SVH
// clock rate in kHz and minimum power-down hold in microseconds
`define SRRS_CLK_KHZ 20000
`define SRRS_PD_MIN_US 2000
// power-down hold count in cycles, rounded up
`define SRRS_PD_MIN_CYC ((`SRRS_PD_MIN_US * `SRRS_CLK_KHZ + 999) / 1000)
// settle cycles for lock after a reset release
`define SRRS_LOCK_CYC 16'h0010
// counter width
`define SRRS_CNT_W 16
// reset, zero and one values
`define SRRS_ZERO2 2'h0
`define SRRS_ZERO3 3'h0
`define SRRS_ZERO32 32'h0000_0000
`define SRRS_ONE32 32'h0000_0001
`define SRRS_ZERO16 16'h0000
`define SRRS_ONE16 16'h0001
`endif

// File: design/srrs_pkg.sv
// types for the transceiver reconfiguration reset and status block
package srrs_pkg;
    // reset sequencer states, gray along the usual path
    typedef enum logic [2:0] {
        SRRS_POWER_DOWN = 3'h0,
        SRRS_PLL_WAIT = 3'h1,
        SRRS_RX_WAIT = 3'h3,
        SRRS_RUN = 3'h2,
        SRRS_RECONFIG = 3'h6
    } srrs_state_t;
endpackage

// File: design/srrs_link_if.sv
// interface joining the transceiver end and the reconfiguration controller end
`timescale 1ns/1ps
interface srrs_link_if;
    logic reconfig_start; // start request for reconfiguration reset
    logic reconfig_done; // reconfiguration finished
    logic reconfig_busy; // controller busy with offset cancellation
    logic powerdown; // quad-wide power-down
    logic tx_pll_locked; // transmit pll locked
    logic rx_pll_locked; // receive cdr locked to reference
    logic rx_freq_locked; // cdr in lock-to-data mode
    logic [1:0] rx_disp_err; // disparity error per code group
    logic [1:0] rx_err_detect; // code or disparity error per code group
    modport xcvr (
        input reconfig_start, reconfig_done, powerdown,
        output reconfig_busy, tx_pll_locked, rx_pll_locked, rx_freq_locked, rx_disp_err, rx_err_detect
    );
    modport ctrl (
        output reconfig_start, reconfig_done, powerdown,
        input reconfig_busy, tx_pll_locked, rx_pll_locked, rx_freq_locked, rx_disp_err, rx_err_detect
    );
endinterface // srrs_link_if

// File: design/srrs_xcvr_end.sv
// transceiver end: reset sequencer and lock and error status
//
// Notes on behaviour
// [RQ1] start request begins reconfiguration reset sequence
// [RQ2] completion input finishes the reconfiguration reset
// [RQ3] start only during rate negotiation writes
// [RQ4] unused negotiation: tie start and done low
// [RQ5] transmit pll lock output, asynchronous
// [RQ6] receive cdr lock output, asynchronous
// [RQ7] lock mode high in lock-to-data
// [RQ8] power-down resets all but reference clocks; here cal_busy_r and the synchronisers are not reset by it
// [RQ9] same-quad users share one power-down
// [RQ10] power-down low or held two ms
// [RQ11] two-bit disparity error flag per group
// [RQ12] error flag: invalid code or disparity
// [RQ13] consumer separates errors using disparity bit
// [RQ14] design includes a reconfiguration block
// [RQ15] busy low first cycle, high during cancellation
// [RQ16] channel held in reset until completion
`timescale 1ns/1ps
`include "srrs_map.svh"
module srrs_xcvr_end
    import srrs_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // link to the reconfiguration controller
    srrs_link_if.xcvr link,
    // raw status from the analog transceiver (other domain)
    input wire logic pll_lock_raw_in,
    input wire logic cdr_lock_raw_in,
    input wire logic cdr_ltd_raw_in,
    input wire logic [1:0] code_err_in,
    input wire logic [1:0] disp_err_in,
    input wire logic cal_done_in,
    // user side status
    output logic chan_reset_out,
    output logic tx_pll_locked_out,
    output logic rx_pll_locked_out,
    output logic rx_ltd_out,
    output logic [1:0] rx_disp_err_out,
    output logic [1:0] rx_err_detect_out
);
    // ==========================================================
    // input synchronisers, three stages each
    // ==========================================================
    logic [2:0] s1_r; // first stage, read only by second
    logic [2:0] s2_r; // second stage
    logic [2:0] s3_r; // third stage
    logic [2:0] lvl_r; // accepted level
    // sync pll lock, cdr lock, cdr mode
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_r <= `SRRS_ZERO3;
            s2_r <= `SRRS_ZERO3;
            s3_r <= `SRRS_ZERO3;
            // locks read as lost until proven, matching the idle pins
            lvl_r <= `SRRS_ZERO3;
        end else begin
            // stage one takes the raw levels from the analog side
            s1_r <= {cdr_ltd_raw_in, cdr_lock_raw_in, pll_lock_raw_in};
            s2_r <= s1_r;
            s3_r <= s2_r;
            // a change counts once stages two and three agree
            for (int i = 0; i < 3; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    lvl_r[i] <= s3_r[i];
                end
            end
        end
    end

    // ==========================================================
    // reset sequencer
    // ==========================================================
    srrs_state_t state_r; // sequencer state
    logic [`SRRS_CNT_W-1:0] cnt_r; // settle counter
    logic cal_busy_r; // offset cancellation running
    logic first_r; // first cycle after reset gone
    // sequencer walks power-down, pll, rx, run, reconfig
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= SRRS_POWER_DOWN;
            cnt_r <= `SRRS_ZERO16;
        end else if (link.powerdown) begin
            // sequencer held in power-down and settle count cleared; offset cancellation busy keeps its value
            state_r <= SRRS_POWER_DOWN; // RQ8
            cnt_r <= `SRRS_ZERO16;
        end else begin
            case (state_r)
                SRRS_POWER_DOWN: begin
                    // power-down gone: start the release order afresh
                    state_r <= SRRS_PLL_WAIT;
                    cnt_r <= `SRRS_ZERO16;
                end
                SRRS_PLL_WAIT: begin
                    // wait for pll lock plus settle time
                    if (lvl_r[0] && cnt_r >= `SRRS_LOCK_CYC) begin
                        // lock has stood long enough, move on to the receiver
                        state_r <= SRRS_RX_WAIT; // RQ16
                        cnt_r <= `SRRS_ZERO16;
                    end else if (lvl_r[0]) begin
                        // locked, count the settle cycles
                        cnt_r <= cnt_r + `SRRS_ONE16;
                    end else begin
                        // lock lost or not yet seen, settle time starts over
                        cnt_r <= `SRRS_ZERO16;
                    end
                end
                SRRS_RX_WAIT: begin
                    // release channel once the cdr locks
                    // offset cancellation still running keeps the channel held
                    if (lvl_r[1] && !cal_busy_r) begin
                        state_r <= SRRS_RUN;
                    end
                end
                SRRS_RUN: begin
                    // start request opens the reconfiguration reset
                    if (link.reconfig_start) begin
                        state_r <= SRRS_RECONFIG; // RQ1
                    end
                end
                SRRS_RECONFIG: begin
                    // completion re-runs the normal release order
                    if (link.reconfig_done) begin
                        state_r <= SRRS_PLL_WAIT; // RQ2 RQ16
                        cnt_r <= `SRRS_ZERO16;
                    end
                end
                default: begin
                    // unused codes fall back to power-down
                    state_r <= SRRS_POWER_DOWN;
                end
            endcase
        end
    end

    // ==========================================================
    // controller busy during offset cancellation
    // ==========================================================
    // low one cycle after reset, then high until calibration done
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            first_r <= 1'b1;
            cal_busy_r <= 1'b0;
        end else begin
            first_r <= 1'b0;
            // raise wins over a done seen in the same cycle
            if (first_r) begin
                cal_busy_r <= 1'b1; // RQ15
            end else if (cal_done_in) begin
                // cancellation finished, controller free
                cal_busy_r <= 1'b0; // RQ15
            end
        end
    end
    // busy is driven from this end for the controller to watch
    assign link.reconfig_busy = cal_busy_r;

    // ==========================================================
    // status outputs, registered
    // ==========================================================
    // channel held in reset unless the sequencer runs
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            chan_reset_out <= 1'b1;
        end else begin
            chan_reset_out <= (state_r != SRRS_RUN); // RQ16
        end
    end

    // lock flags, pll locks dropped at once while power-down holds, lock-to-data a cycle later with the sequencer
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_pll_locked_out <= 1'b0;
            rx_pll_locked_out <= 1'b0;
            rx_ltd_out <= 1'b0;
        end else begin
            tx_pll_locked_out <= lvl_r[0] && !link.powerdown; // RQ5
            rx_pll_locked_out <= lvl_r[1] && !link.powerdown; // RQ6
            // lock-to-data only reported once the channel runs
            rx_ltd_out <= lvl_r[2] && (state_r == SRRS_RUN); // RQ7
        end
    end

    // code group flags pass only while the channel runs
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_disp_err_out <= `SRRS_ZERO2;
            rx_err_detect_out <= `SRRS_ZERO2;
        end else if (state_r == SRRS_RUN) begin
            // bit one and bit zero follow their own code group
            rx_disp_err_out <= disp_err_in; // RQ11
            // a disparity error also counts as a receive error
            rx_err_detect_out <= disp_err_in | code_err_in; // RQ12
        end else begin
            // receive path held in reset, flags read quiet
            rx_disp_err_out <= `SRRS_ZERO2;
            rx_err_detect_out <= `SRRS_ZERO2;
        end
    end

    // ==========================================================
    // link outputs
    // ==========================================================
    // the controller end sees the same registered status
    assign link.tx_pll_locked = tx_pll_locked_out;
    assign link.rx_pll_locked = rx_pll_locked_out;
    assign link.rx_freq_locked = rx_ltd_out;
    assign link.rx_disp_err = rx_disp_err_out;
    assign link.rx_err_detect = rx_err_detect_out;
endmodule // srrs_xcvr_end

// File: design/srrs_ctrl_end.sv
// controller end: start and done requests and power-down hold
`timescale 1ns/1ps
`include "srrs_map.svh"
module srrs_ctrl_end
    import srrs_pkg::*;
#(
    // power-down minimum hold in cycles
    parameter int unsigned PD_MIN_CYC = `SRRS_PD_MIN_CYC
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // user requests
    input wire logic neg_en_in,
    input wire logic neg_write_in,
    input wire logic neg_done_in,
    input wire logic pd_req_in,
    // link
    srrs_link_if.ctrl link,
    // user status
    output logic pd_out,
    output logic start_out,
    output logic done_out,
    output logic [1:0] code_viol_out,
    output logic [1:0] disp_viol_out
);
    // ==========================================================
    // rate negotiation requests
    // ==========================================================
    // start only on negotiation writes, else held low
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            start_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            start_out <= neg_en_in && neg_write_in; // RQ3 RQ4
            done_out <= neg_en_in && neg_done_in; // RQ4
        end
    end
    assign link.reconfig_start = start_out;
    assign link.reconfig_done = done_out;

    // ==========================================================
    // power-down with minimum hold, shared by the quad
    // ==========================================================
    logic [31:0] pd_cnt_r; // cycles left in hold
    // once asserted, held for at least the minimum time
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pd_out <= 1'b0;
            pd_cnt_r <= `SRRS_ZERO32;
        end else if (!pd_out && pd_req_in) begin
            pd_out <= 1'b1; // RQ9
            pd_cnt_r <= PD_MIN_CYC - `SRRS_ONE32; // RQ10
        end else if (pd_cnt_r != `SRRS_ZERO32) begin
            pd_cnt_r <= pd_cnt_r - `SRRS_ONE32; // RQ10
        end else begin
            pd_out <= pd_req_in;
        end
    end
    assign link.powerdown = pd_out;

    // ==========================================================
    // error classification
    // ==========================================================
    // disparity bit tells the two error kinds apart
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            code_viol_out <= `SRRS_ZERO2;
            disp_viol_out <= `SRRS_ZERO2;
        end else begin
            disp_viol_out <= link.rx_disp_err;
            code_viol_out <= link.rx_err_detect & ~link.rx_disp_err; // RQ13
        end
    end
endmodule // srrs_ctrl_end

// File: bench/srrs_link_chk.sv
// assertion checker watching the reconfiguration link between both ends
`timescale 1ns/1ps
module srrs_link_chk #(
    parameter int unsigned PD_MIN_CYC = 40000 // power-down minimum hold in cycles
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // link signals
    input wire logic reconfig_start,
    input wire logic reconfig_done,
    input wire logic reconfig_busy,
    input wire logic powerdown,
    input wire logic tx_pll_locked,
    input wire logic rx_pll_locked,
    input wire logic rx_freq_locked,
    input wire logic [1:0] rx_disp_err,
    input wire logic [1:0] rx_err_detect
);
    // ====================
    // helper counter
    logic [31:0] pd_hi_r; // cycles the current power-down has stood
    // count the length of each power-down assertion
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pd_hi_r <= 32'h0;
        end else if (powerdown) begin
            pd_hi_r <= pd_hi_r + 32'h1;
        end else begin
            pd_hi_r <= 32'h0;
        end
    end
    // ====================
    // link assertions
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    busy_init_a: assert property ($rose(rst_n_in) |-> !reconfig_busy ##2 reconfig_busy)
        else $error("busy not raised two cycles after reset");
    busy_quiet_a: assert property (reconfig_busy |-> rx_err_detect == 2'h0 && !rx_freq_locked)
        else $error("status active during calibration");
    rst_quiet_a: assert property ($rose(rst_n_in) |-> rx_err_detect == 2'h0 && !powerdown)
        else $error("outputs not cleared by reset");
    err_cover_a: assert property ((rx_disp_err & ~rx_err_detect) == 2'h0)
        else $error("disparity bit without error bit");
    pd_len_a: assert property ($fell(powerdown) |-> pd_hi_r >= PD_MIN_CYC)
        else $error("power-down released too early");
    pd_quiet_a: assert property (powerdown [*4] |-> !rx_freq_locked && rx_err_detect == 2'h0)
        else $error("status active in power-down");
    start_quiet_a: assert property (reconfig_start |-> ##3 (rx_err_detect == 2'h0 && !rx_freq_locked))
        else $error("receive path live after start");
    done_quiet_a: assert property (reconfig_done && !rx_freq_locked |-> ##1 (!rx_freq_locked) [*8])
        else $error("channel released too soon after done");
endmodule // srrs_link_chk

// File: bench/serdes_reconfig_reset_status_test.sv
// self-checking bench joining both ends of the reconfiguration link
`timescale 1ns/1ps
module serdes_reconfig_reset_status_test;
    localparam int PD_CYC = 8; // shortened power-down hold
    // ====================
    // stimulus and observed signals
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic pll_lock_raw_in = 1'b0, cdr_lock_raw_in = 1'b0, cdr_ltd_raw_in = 1'b0, cal_done_in = 1'b0;
    logic [1:0] code_err_in = 2'h0, disp_err_in = 2'h0;
    logic neg_en_in = 1'b0, neg_write_in = 1'b0, neg_done_in = 1'b0, pd_req_in = 1'b0;
    logic chan_reset_out, tx_pll_locked_out, rx_pll_locked_out, rx_ltd_out, pd_out, start_out, done_out;
    logic [1:0] rx_disp_err_out, rx_err_detect_out, code_viol_out, disp_viol_out;
    int failures = 0, n_checks = 0, cycles = 0, seed = 32'h49418c13, k, n;
    logic [3:0] flag_q[$], split_q[$]; // model of the expected code group flags
    // ====================
    // clock, link and both ends
    always #25 ref_clk_in = ~ref_clk_in;
    srrs_link_if link();
    srrs_xcvr_end srrs_xcvr_end_i (.ref_clk_in, .rst_n_in, .link(link), .pll_lock_raw_in, .cdr_lock_raw_in,
        .cdr_ltd_raw_in, .code_err_in, .disp_err_in, .cal_done_in, .chan_reset_out, .tx_pll_locked_out,
        .rx_pll_locked_out, .rx_ltd_out, .rx_disp_err_out, .rx_err_detect_out);
    srrs_ctrl_end #(.PD_MIN_CYC(PD_CYC)) srrs_ctrl_end_i (.ref_clk_in, .rst_n_in, .neg_en_in, .neg_write_in,
        .neg_done_in, .pd_req_in, .link(link), .pd_out, .start_out, .done_out, .code_viol_out, .disp_viol_out);
    srrs_link_chk #(.PD_MIN_CYC(PD_CYC)) chk_i (.ref_clk_in, .rst_n_in, .reconfig_start(link.reconfig_start),
        .reconfig_done(link.reconfig_done), .reconfig_busy(link.reconfig_busy), .powerdown(link.powerdown),
        .tx_pll_locked(link.tx_pll_locked), .rx_pll_locked(link.rx_pll_locked),
        .rx_freq_locked(link.rx_freq_locked), .rx_disp_err(link.rx_disp_err), .rx_err_detect(link.rx_err_detect));
    // ====================
    // compare, wait and report helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // wait for the channel reset level, n counts the cycles taken
    task automatic wait_rst(input logic v);
        n = 0;
        while (chan_reset_out !== v && n < 300) begin
            @(negedge ref_clk_in);
            n++;
        end
    endtask
    task automatic final_report;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // hang guard
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            $display("Error at %0t: timeout", $time);
            final_report();
        end
    end
    // ====================
    // main sequence
    initial begin
        repeat (6) @(negedge ref_clk_in);
        rst_n_in = 1'b1;
        repeat (3) @(negedge ref_clk_in);
        chk({link.reconfig_busy, chan_reset_out}, 2'h3, "calibration start");
        {pll_lock_raw_in, cdr_lock_raw_in, cdr_ltd_raw_in} = 3'h7;
        repeat (40) @(negedge ref_clk_in);
        chk({link.reconfig_busy, chan_reset_out, tx_pll_locked_out}, 3'h7, "held while busy");
        cal_done_in = 1'b1;
        wait_rst(1'b0);
        chk({link.reconfig_busy, tx_pll_locked_out, rx_pll_locked_out, rx_ltd_out}, 4'h7, "locks up");
        cdr_ltd_raw_in = 1'b0;
        repeat (6) @(negedge ref_clk_in);
        chk({rx_ltd_out, link.rx_freq_locked}, 2'h0, "reference mode");
        cdr_ltd_raw_in = 1'b1;
        // random code group errors, held until settled then compared with the model
        for (k = 0; k < 24; k++) begin
            {code_err_in, disp_err_in} = 4'($random(seed));
            // model: disparity per group, then disparity or code error per group
            flag_q.push_back({disp_err_in, disp_err_in | code_err_in});
            split_q.push_back({disp_err_in, code_err_in & ~disp_err_in});
            repeat (5) @(negedge ref_clk_in);
            chk({rx_disp_err_out, rx_err_detect_out}, flag_q.pop_front(), "flags");
            chk({disp_viol_out, code_viol_out}, split_q.pop_front(), "split");
        end
        // stray done in run is refused
        neg_en_in = 1'b1;
        neg_done_in = 1'b1;
        repeat (3) @(negedge ref_clk_in);
        neg_done_in = 1'b0;
        neg_en_in = 1'b0;
        neg_write_in = 1'b1;
        repeat (4) @(negedge ref_clk_in);
        chk({start_out, link.reconfig_start, chan_reset_out}, 3'h0, "negotiation off");
        neg_en_in = 1'b1;
        @(negedge ref_clk_in);
        chk(start_out, 1'b1, "start issued");
        neg_write_in = 1'b0;
        repeat (12) @(negedge ref_clk_in);
        chk({chan_reset_out, rx_err_detect_out, rx_ltd_out}, 4'h8, "held in reconfig");
        neg_done_in = 1'b1;
        @(negedge ref_clk_in);
        neg_done_in = 1'b0;
        wait_rst(1'b0);
        chk({n >= 17, chan_reset_out}, 2'h2, "release order");
        // power-down pulse must stretch to the minimum hold
        n = 0;
        pd_req_in = 1'b1;
        for (k = 0; k < 14; k++) begin
            @(negedge ref_clk_in);
            pd_req_in = 1'b0;
            n += int'(pd_out);
            if (k == 5) chk({chan_reset_out, rx_err_detect_out}, 3'h4, "powered down");
            if (k == 5) chk({link.powerdown, pd_out}, 2'h3, "shared power-down");
        end
        chk(n == PD_CYC || n == PD_CYC + 1, 1'b1, "power-down hold");
        wait_rst(1'b0);
        chk({chan_reset_out, tx_pll_locked_out, rx_ltd_out}, 3'h3, "recovered");
        final_report();
    end
endmodule // serdes_reconfig_reset_status_test
